// [hdl/supervisor_pkg.sv]
/*
  Constants, mode encodings and register map of the supply and thermal supervisor.
  Assumes a 10 MHz clock and a plain register port with one-cycle read latency.
*/
// Function
// - Power-on sets flag; reset held till delay
// - Battery loss resets; restart in init
// - Battery undervoltage sets only its flag
// - Undervoltage disables short protection, thermal stays
// - Stop mode skips battery monitoring mostly
// - Battery overvoltage monitored, sticky after pump off
// - Prewarning sets only warning flag
// - Main undervoltage resets, restart, flag at release
// - Hysteresis bit selects highest rising threshold
// - Sleep sets no main-output flags
// - Overvoltage with config one: restart, self-clear
// - Overvoltage with config zero: fail-safe
// - Main output short: flag, off, fail-safe
// - Short fail-safe wakes on bus, wake, pin
// - Aux and transceiver undervoltage sticky flags
// - Block overtemperature switches off, sets flag
// - Aux thermal clears enable, sets flag
// - Transceiver thermal stops transmitter, fault 01
// - Prewarning temperature sets sticky flag
// - Chip thermal: fail-safe, wait, restart, normal
// - Count chip thermal events; extend wait 64x
// - Chip thermal while entering sleep: fail-safe
package supervisor_pkg;

  typedef enum logic [2:0]
  {
    mode_init = 3'b000,
    mode_normal = 3'b001,
    mode_stop = 3'b010,
    mode_sleep = 3'b011,
    mode_restart = 3'b100,
    mode_failsafe = 3'b101
  } mode_type;

  localparam int unsigned CLOCK_HZ = 10000000;
  localparam int unsigned RESET_DELAY_US = 10000;
  localparam int unsigned RESET_DELAY_CYCLES = RESET_DELAY_US * (CLOCK_HZ / 1000000);
  localparam int unsigned SHORT_FILTER_US = 2000;
  localparam int unsigned SHORT_FILTER_CYCLES = SHORT_FILTER_US * (CLOCK_HZ / 1000000);
  localparam int unsigned THERMAL_WAIT_US = 1000;
  localparam int unsigned THERMAL_WAIT_CYCLES = THERMAL_WAIT_US * (CLOCK_HZ / 1000000);
  localparam int unsigned WAIT_EXTEND = 64;
  localparam logic [4:0] THERMAL_COUNT_LIMIT = 5'h10;
  localparam logic [1:0] XCVR_FAULT_THERMAL = 2'h1;

  localparam logic [3:0] ADDR_STATUS = 4'h0;
  localparam logic [3:0] ADDR_CONTROL = 4'h1;
  localparam logic [3:0] ADDR_MODE = 4'h2;
  localparam logic [15:0] CONTROL_RESET = 16'h0000;

  // Status bit positions; write one to clear
  localparam int POS_POWER_ON = 0;
  localparam int POS_BAT_UNDER = 1;
  localparam int POS_BAT_OVER = 2;
  localparam int POS_PREWARN = 3;
  localparam int POS_MAIN_UNDER = 4;
  localparam int POS_MAIN_OVER = 5;
  localparam int POS_SHORT = 6;
  localparam int POS_AUX_UNDER = 7;
  localparam int POS_XCVR_UNDER = 8;
  localparam int POS_BLOCK_THERM = 9;
  localparam int POS_AUX_OT = 10;
  localparam int POS_TEMP_PREWARN = 11;
  localparam int POS_CHIP_THERM = 12;
  localparam int POS_SAFE = 13;
  localparam int POS_FAILURE = 14;
  localparam int FLAG_COUNT = 15;
  // Power-on flag alone after reset
  localparam logic [FLAG_COUNT-1:0] FLAG_RESET = 15'h0001;

  // Control bit positions
  localparam int POS_HYST_SEL = 0;
  localparam int POS_OV_RST_EN = 1;
  localparam int POS_CFG_STATE = 2;
  localparam int POS_AUX_EN = 3;
  localparam int POS_XCVR_EN = 4;
  localparam int POS_EXTEND_EN = 5;
  localparam int POS_PUMP_EN = 6;
  localparam int POS_GPIO_WAKE = 7;
  localparam int POS_SLEEP_REQ = 8;
  localparam int POS_STOP_REQ = 9;
  localparam int POS_NORMAL_REQ = 10;

endpackage

// [hdl/supply_thermal_supervisor.sv]
/*
  Supply and thermal supervision: sticky flags, reset output, fail output, mode machine.
  Assumes detector inputs are raw levels, synchronised here, and a power-on reset on reset_n.
*/
`timescale 1ns/100ps
`default_nettype none
module supply_thermal_supervisor
(
  input wire logic clock,
  input wire logic reset_n,
  input wire logic battery_por_low,
  input wire logic battery_under,
  input wire logic battery_over,
  input wire logic main_prewarn,
  input wire logic main_under,
  input wire logic main_above_rt1,
  input wire logic main_over,
  input wire logic load_above_peak,
  input wire logic aux_under,
  input wire logic xcvr_under,
  input wire logic aux_hot,
  input wire logic xcvr_hot,
  input wire logic main_hot_prewarn,
  input wire logic chip_hot,
  input wire logic bus_wake,
  input wire logic wake_input,
  input wire logic gpio_wake,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [15:0] reg_rdata,
  output logic reset_out_n,
  output logic fail_output,
  output logic main_out_enable,
  output logic aux_out_enable,
  output logic xcvr_tx_enable,
  output logic [1:0] xcvr_fault,
  output supervisor_pkg::mode_type mode
);
  import supervisor_pkg::*;

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  localparam int NSYNC = 17;
  wire [NSYNC-1:0] raw_in = {gpio_wake, wake_input, bus_wake, chip_hot, main_hot_prewarn, xcvr_hot, aux_hot,
    xcvr_under, aux_under, load_above_peak, main_over, main_above_rt1, main_under, main_prewarn,
    battery_over, battery_under, battery_por_low};
  logic [NSYNC-1:0] meta_ff;
  logic [NSYNC-1:0] sync_ff;
  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++)
    begin : g_sync
      always_ff @(posedge clock)
      begin
        meta_ff[gi] <= reset_n ? raw_in[gi] : 1'b0;
        sync_ff[gi] <= reset_n ? meta_ff[gi] : 1'b0;
      end
    end
  endgenerate
  wire s_por_low = sync_ff[0];
  wire s_bat_under = sync_ff[1];
  wire s_bat_over = sync_ff[2];
  wire s_prewarn = sync_ff[3];
  wire s_main_under = sync_ff[4];
  wire s_above_rt1 = sync_ff[5];
  wire s_main_over = sync_ff[6];
  wire s_peak = sync_ff[7];
  wire s_aux_under = sync_ff[8];
  wire s_xcvr_under = sync_ff[9];
  wire s_aux_hot = sync_ff[10];
  wire s_xcvr_hot = sync_ff[11];
  wire s_temp_pw = sync_ff[12];
  wire s_chip_hot = sync_ff[13];
  wire s_bus_wake = sync_ff[14];
  wire s_wake = sync_ff[15];
  wire s_gpio_wake = sync_ff[16];

  // ----------------------------------------
  // State
  // ----------------------------------------
  mode_type mode_ff, nxt_mode;
  logic [FLAG_COUNT-1:0] flag_ff, nxt_flag;
  logic [15:0] ctrl_ff, nxt_ctrl;
  logic [23:0] timer_ff, nxt_timer;
  logic [4:0] tcount_ff, nxt_tcount;
  logic rst_low_ff, nxt_rst_low;
  logic fail_ff, nxt_fail;
  logic main_on_ff, nxt_main_on;
  logic short_trip_ff, nxt_short_trip;
  logic ov_restart_ff, nxt_ov_restart;
  logic hot_prev_ff;
  logic main_ok_prev_ff;
  logic [15:0] rdata_ff, nxt_rdata;

  // ----------------------------------------
  // Decode and events
  // ----------------------------------------
  wire wr_status = reg_write && reg_addr == ADDR_STATUS;
  wire wr_ctrl = reg_write && reg_addr == ADDR_CONTROL;
  wire [FLAG_COUNT-1:0] clr = wr_status ? reg_wdata[FLAG_COUNT-1:0] : '0;
  wire active_mode = mode_ff == mode_init || mode_ff == mode_restart || mode_ff == mode_normal;
  wire stop_watch = mode_ff == mode_stop && (s_peak || s_prewarn);
  wire bat_watch = active_mode || stop_watch;
  wire over_watch = bat_watch || ctrl_ff[POS_PUMP_EN];
  wire main_watch = main_on_ff && mode_ff != mode_sleep;
  // Hysteresis selects the highest rising threshold for release
  wire main_ok = ctrl_ff[POS_HYST_SEL] ? s_above_rt1 : !s_main_under;
  wire hot_rise = s_chip_hot && !hot_prev_ff;
  wire hot_fall = !s_chip_hot && hot_prev_ff;
  wire aux_on = ctrl_ff[POS_AUX_EN];
  wire aux_trip = aux_on && s_aux_hot;
  wire xcvr_trip = ctrl_ff[POS_XCVR_EN] && s_xcvr_hot;
  wire short_en = !s_bat_under;
  wire short_timeout = short_en && main_on_ff && !main_ok && timer_ff >= 24'(SHORT_FILTER_CYCLES - 1);
  wire wake_any = s_bus_wake || s_wake || (s_gpio_wake && ctrl_ff[POS_GPIO_WAKE]);
  wire over_rst = s_main_over && main_watch && ctrl_ff[POS_OV_RST_EN];
  wire chip_clr_ok = clr[POS_CHIP_THERM] && !s_chip_hot && mode_ff == mode_normal;
  wire [23:0] thermal_wait = flag_ff[POS_SAFE] ? 24'(THERMAL_WAIT_CYCLES * WAIT_EXTEND)
    : 24'(THERMAL_WAIT_CYCLES);

  // ----------------------------------------
  // Flags, counter, control
  // ----------------------------------------
  always_comb
  begin
    nxt_flag = flag_ff;
    // Clears only where allowed by the present condition; sets always win
    if (clr[POS_POWER_ON]) nxt_flag[POS_POWER_ON] = 1'b0;
    if (clr[POS_BAT_UNDER] && !s_bat_under) nxt_flag[POS_BAT_UNDER] = 1'b0;
    if (clr[POS_BAT_OVER]) nxt_flag[POS_BAT_OVER] = 1'b0;
    if (clr[POS_PREWARN]) nxt_flag[POS_PREWARN] = 1'b0;
    if (clr[POS_MAIN_UNDER]) nxt_flag[POS_MAIN_UNDER] = 1'b0;
    if (clr[POS_MAIN_OVER]) nxt_flag[POS_MAIN_OVER] = 1'b0;
    if (clr[POS_SHORT]) nxt_flag[POS_SHORT] = 1'b0;
    if (clr[POS_AUX_UNDER]) nxt_flag[POS_AUX_UNDER] = 1'b0;
    if (clr[POS_XCVR_UNDER]) nxt_flag[POS_XCVR_UNDER] = 1'b0;
    if (clr[POS_BLOCK_THERM] && !s_aux_hot && !s_xcvr_hot) nxt_flag[POS_BLOCK_THERM] = 1'b0;
    if (clr[POS_AUX_OT] && !s_aux_hot) nxt_flag[POS_AUX_OT] = 1'b0;
    if (clr[POS_TEMP_PREWARN] && !s_temp_pw) nxt_flag[POS_TEMP_PREWARN] = 1'b0;
    if (chip_clr_ok) nxt_flag[POS_CHIP_THERM] = 1'b0;
    if (clr[POS_SAFE]) nxt_flag[POS_SAFE] = 1'b0;
    if (clr[POS_FAILURE]) nxt_flag[POS_FAILURE] = 1'b0;
    if (bat_watch && s_bat_under) nxt_flag[POS_BAT_UNDER] = 1'b1;
    if (over_watch && s_bat_over) nxt_flag[POS_BAT_OVER] = 1'b1;
    if (main_watch && s_prewarn) nxt_flag[POS_PREWARN] = 1'b1;
    if (main_watch && mode_ff == mode_restart && rst_low_ff && !nxt_rst_low && !ov_restart_ff)
      nxt_flag[POS_MAIN_UNDER] = 1'b1;
    if (main_watch && s_main_over) nxt_flag[POS_MAIN_OVER] = 1'b1;
    if (short_timeout)
    begin
      nxt_flag[POS_SHORT] = 1'b1;
      nxt_flag[POS_FAILURE] = 1'b1;
    end
    if (aux_on && s_aux_under && timer_ff >= 24'(SHORT_FILTER_CYCLES - 1) && mode_ff != mode_sleep)
      nxt_flag[POS_AUX_UNDER] = 1'b1;
    if (ctrl_ff[POS_XCVR_EN] && s_xcvr_under) nxt_flag[POS_XCVR_UNDER] = 1'b1;
    if (aux_trip || xcvr_trip) nxt_flag[POS_BLOCK_THERM] = 1'b1;
    if (aux_trip) nxt_flag[POS_AUX_OT] = 1'b1;
    if (s_temp_pw) nxt_flag[POS_TEMP_PREWARN] = 1'b1;
    if (hot_rise) nxt_flag[POS_CHIP_THERM] = 1'b1;
    // Set on the event that reaches the limit, so software can clear it
    if (ctrl_ff[POS_EXTEND_EN] && hot_rise && tcount_ff == THERMAL_COUNT_LIMIT - 5'h01)
      nxt_flag[POS_SAFE] = 1'b1;
  end

  always_comb
  begin
    nxt_tcount = tcount_ff;
    if (chip_clr_ok || !ctrl_ff[POS_EXTEND_EN])
      nxt_tcount = '0;
    if (hot_rise && tcount_ff != THERMAL_COUNT_LIMIT)
      nxt_tcount = tcount_ff + 5'h01;
  end

  always_comb
  begin
    nxt_ctrl = wr_ctrl ? reg_wdata : ctrl_ff;
    nxt_ctrl[POS_SLEEP_REQ] = wr_ctrl & reg_wdata[POS_SLEEP_REQ];
    nxt_ctrl[POS_STOP_REQ] = wr_ctrl & reg_wdata[POS_STOP_REQ];
    nxt_ctrl[POS_NORMAL_REQ] = wr_ctrl & reg_wdata[POS_NORMAL_REQ];
    if (aux_trip) nxt_ctrl[POS_AUX_EN] = 1'b0;
    if (ov_restart_ff && mode_ff == mode_restart && !nxt_rst_low) nxt_ctrl[POS_OV_RST_EN] = 1'b0;
  end

  // ----------------------------------------
  // Mode machine
  // ----------------------------------------
  always_comb
  begin
    nxt_mode = mode_ff;
    nxt_timer = timer_ff + 24'h000001;
    nxt_rst_low = rst_low_ff;
    nxt_fail = fail_ff;
    nxt_main_on = main_on_ff;
    nxt_short_trip = short_trip_ff;
    nxt_ov_restart = ov_restart_ff;
    if (main_ok != main_ok_prev_ff) nxt_timer = '0;
    unique case (mode_ff)
      mode_init, mode_restart:
      begin
        // Timer also runs while low, so the short filter can expire
        if (((main_ok && main_ok_prev_ff) || ov_restart_ff) && timer_ff >= 24'(RESET_DELAY_CYCLES - 1))
        begin
          nxt_rst_low = 1'b0;
          nxt_mode = mode_normal;
          nxt_ov_restart = 1'b0;
          nxt_timer = '0;
        end
      end
      mode_normal, mode_stop:
      begin
        if (ctrl_ff[POS_SLEEP_REQ])
          nxt_mode = mode_sleep;
        else if (ctrl_ff[POS_STOP_REQ])
          nxt_mode = mode_stop;
        else if (ctrl_ff[POS_NORMAL_REQ])
          nxt_mode = mode_normal;
        if (main_watch && !main_ok && !short_timeout)
        begin
          nxt_mode = mode_restart;
          nxt_rst_low = 1'b1;
          nxt_timer = '0;
        end
      end
      mode_sleep:
      begin
        nxt_main_on = 1'b0;
        if (wake_any)
        begin
          nxt_mode = mode_restart;
          nxt_main_on = 1'b1;
          nxt_rst_low = 1'b1;
          nxt_timer = '0;
        end
      end
      mode_failsafe:
      begin
        if (short_trip_ff)
        begin
          nxt_timer = '0;
          if (wake_any)
          begin
            nxt_short_trip = 1'b0;
            nxt_main_on = 1'b1;
            nxt_mode = mode_restart;
          end
        end
        else if (!s_chip_hot && !fail_ff && timer_ff >= thermal_wait - 24'h000001)
        begin
          nxt_mode = mode_restart;
          nxt_timer = '0;
        end
      end
      default:
        nxt_mode = mode_init;
    endcase
    // One restart per event; the reset delay ends it though overvoltage stays
    if (over_rst && mode_ff != mode_failsafe && !ov_restart_ff)
    begin
      nxt_fail = 1'b1;
      nxt_rst_low = 1'b1;
      nxt_timer = '0;
      if (ctrl_ff[POS_CFG_STATE])
      begin
        nxt_mode = mode_restart;
        nxt_ov_restart = 1'b1;
      end
      else
        nxt_mode = mode_failsafe;
    end
    if (short_timeout)
    begin
      nxt_mode = mode_failsafe;
      nxt_main_on = 1'b0;
      nxt_fail = 1'b1;
      nxt_rst_low = 1'b1;
      nxt_short_trip = 1'b1;
    end
    if (hot_rise)
    begin
      nxt_mode = mode_failsafe;
      nxt_rst_low = 1'b1;
      nxt_timer = '0;
    end
    if (hot_fall) nxt_timer = '0;
    if (mode_ff == mode_failsafe && s_chip_hot) nxt_timer = '0;
  end

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  wire [15:0] status_word = 16'(flag_ff);
  wire [15:0] mode_word = {11'h000, xcvr_fault, mode_ff};
  wire [15:0] rd_sel = reg_addr == ADDR_STATUS ? status_word : reg_addr == ADDR_CONTROL ? ctrl_ff
    : reg_addr == ADDR_MODE ? mode_word : 16'h0000;
  assign nxt_rdata = reg_read ? rd_sel : 16'h0000;

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  // Battery loss acts as reset: all state but the synchronisers returns to init
  wire por = !reset_n || s_por_low;
  always_ff @(posedge clock)
  begin
    if (por)
    begin
      mode_ff <= mode_init;
      flag_ff <= FLAG_RESET;
      ctrl_ff <= CONTROL_RESET;
      timer_ff <= 24'h000000;
      tcount_ff <= 5'h00;
      rst_low_ff <= 1'b1;
      fail_ff <= 1'b0;
      main_on_ff <= 1'b1;
      short_trip_ff <= 1'b0;
      ov_restart_ff <= 1'b0;
      hot_prev_ff <= 1'b0;
      main_ok_prev_ff <= 1'b0;
      rdata_ff <= 16'h0000;
    end
    else
    begin
      mode_ff <= nxt_mode;
      flag_ff <= nxt_flag;
      ctrl_ff <= nxt_ctrl;
      timer_ff <= nxt_timer;
      tcount_ff <= nxt_tcount;
      rst_low_ff <= nxt_rst_low;
      fail_ff <= wr_status && reg_wdata[POS_FAILURE] && !nxt_flag[POS_FAILURE] ? 1'b0 : nxt_fail;
      main_on_ff <= nxt_main_on;
      short_trip_ff <= nxt_short_trip;
      ov_restart_ff <= nxt_ov_restart;
      hot_prev_ff <= s_chip_hot;
      main_ok_prev_ff <= main_ok;
      rdata_ff <= nxt_rdata;
    end
  end

  assign reg_rdata = rdata_ff;
  assign reset_out_n = !rst_low_ff;
  assign fail_output = fail_ff;
  assign main_out_enable = main_on_ff;
  assign aux_out_enable = ctrl_ff[POS_AUX_EN];
  assign xcvr_tx_enable = ctrl_ff[POS_XCVR_EN] && !s_xcvr_hot;
  assign xcvr_fault = (ctrl_ff[POS_XCVR_EN] && s_xcvr_hot) ? XCVR_FAULT_THERMAL : 2'h0;
  assign mode = mode_ff;

endmodule // supply_thermal_supervisor
`default_nettype wire

// [test/host_model.sv]
/*
  Host controller model: master of the register port.
  Assumes one-cycle strobes and read data only in the following cycle.
*/
`timescale 1ns/100ps
`default_nettype none
module host_model
(
  input wire logic clock,
  input wire logic [15:0] reg_rdata,
  output logic [3:0] reg_addr,
  output logic [15:0] reg_wdata,
  output logic reg_write,
  output logic reg_read
);
  initial
  begin
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    reg_write = 1'b0;
    reg_read = 1'b0;
  end
  // ------------------------------
  // Bus cycles
  // ------------------------------
  task automatic write_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
    reg_wdata <= ~d;
  endtask
  task automatic read_reg(input logic [3:0] a, output logic [15:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    @(posedge clock);
    d = reg_rdata;
  endtask
endmodule // host_model
`default_nettype wire

// [test/supervisor_assertions.sv]
/*
  Port checks of the supply and thermal supervisor.
  Assumes two-flop synchronisers on detector inputs; bound to the top module.
*/
`timescale 1ns/100ps
`default_nettype none
module supervisor_checker
(
  input wire logic clock,
  input wire logic reset_n,
  input wire logic battery_por_low,
  input wire logic aux_hot,
  input wire logic xcvr_hot,
  input wire logic chip_hot,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [15:0] reg_rdata,
  input wire logic reset_out_n,
  input wire logic fail_output,
  input wire logic aux_out_enable,
  input wire logic xcvr_tx_enable,
  input wire supervisor_pkg::mode_type mode
);
  import supervisor_pkg::*;
  // ------------------------------
  // Properties
  // ------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!reset_n);
  por_reset_a: assert property (
    battery_por_low [*3] |=> mode == mode_init && !reset_out_n && !fail_output)
    else $error("power loss did not reset");
  chip_failsafe_a: assert property ((chip_hot && !battery_por_low) [*4] |=> mode == mode_failsafe)
    else $error("no fail-safe on chip heat");
  failsafe_hold_a: assert property (
    (mode == mode_failsafe && chip_hot && !battery_por_low) [*3] |=> mode == mode_failsafe)
    else $error("fail-safe left while hot");
  no_sleep_hot_a: assert property (chip_hot [*4] |=> mode != mode_sleep)
    else $error("sleep while chip hot");
  xcvr_off_a: assert property (xcvr_hot [*4] |-> !xcvr_tx_enable)
    else $error("transmitter on while hot");
  aux_off_a: assert property (aux_hot [*4] |=> !aux_out_enable)
    else $error("aux output on while hot");
  aux_stays_off_a: assert property ((!aux_out_enable && !reg_write) [*3] |=> !aux_out_enable)
    else $error("aux output on without write");
  fail_mode_a: assert property (
    $rose(fail_output) |-> ##[0:2] (mode == mode_failsafe || mode == mode_restart))
    else $error("fail output in wrong mode");
  read_idle_a: assert property (!$past(reg_read) |-> reg_rdata == 16'h0000)
    else $error("read data without read");
  cover property (mode == mode_failsafe);
  cover property ($fell(aux_out_enable));
  cover property ($fell(xcvr_tx_enable));
endmodule // supervisor_checker
bind supply_thermal_supervisor supervisor_checker chk_u
(
  .clock, .reset_n, .battery_por_low, .aux_hot, .xcvr_hot, .chip_hot, .reg_write, .reg_read,
  .reg_rdata, .reset_out_n, .fail_output, .aux_out_enable, .xcvr_tx_enable, .mode
);
`default_nettype wire

// [test/tb_supply_thermal_supervisor.sv]
/*
  Self-checking bench of the supply and thermal supervisor.
  Assumes host_model as register master and the checker bound to the design.
*/
`timescale 1ns/100ps
`default_nettype none
module tb_supply_thermal_supervisor;
  import supervisor_pkg::*;
  logic clock, reset_n, battery_por_low, battery_under, battery_over, main_prewarn, main_under, main_above_rt1;
  logic main_over, load_above_peak, aux_under, xcvr_under, aux_hot, xcvr_hot, main_hot_prewarn, chip_hot;
  logic bus_wake, wake_input, gpio_wake, reg_write, reg_read, reset_out_n, fail_output, main_out_enable;
  logic aux_out_enable, xcvr_tx_enable;
  logic [3:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata;
  logic [1:0] xcvr_fault;
  mode_type mode;
  int n_mismatch, cmp_count;
  supply_thermal_supervisor dut_u
  (
    .clock, .reset_n, .battery_por_low, .battery_under, .battery_over, .main_prewarn, .main_under,
    .main_above_rt1, .main_over, .load_above_peak, .aux_under, .xcvr_under, .aux_hot, .xcvr_hot,
    .main_hot_prewarn, .chip_hot, .bus_wake, .wake_input, .gpio_wake, .reg_addr, .reg_wdata, .reg_write,
    .reg_read, .reg_rdata, .reset_out_n, .fail_output, .main_out_enable, .aux_out_enable,
    .xcvr_tx_enable, .xcvr_fault, .mode
  );
  host_model host_u
  (
    .clock, .reg_rdata, .reg_addr, .reg_wdata, .reg_write, .reg_read
  );
  initial
  begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  // ------------------------------
  // Helpers
  // ------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("mismatch at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [15:0] m, input logic [15:0] e);
    logic [15:0] d;
    host_u.read_reg(a, d);
    chk(d & m, e);
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic wait_mode(input mode_type m);
    @(posedge clock);
    for (int i = 0; i < 20 && mode !== m; i++)
      @(posedge clock);
    chk({13'h0000, mode}, {13'h0000, m});
  endtask
  task automatic give_verdict();
    $display("comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // ------------------------------
  // Scenarios
  // ------------------------------
  task automatic sc_power_on();
    rd_chk(ADDR_STATUS, 16'hFFFF, 16'h0001);
    {bus_wake, wake_input, gpio_wake} <= 3'h7;
    step(4);
    {bus_wake, wake_input, gpio_wake} <= 3'h0;
    wait_mode(mode_init);
    chk({14'h0000, reset_out_n, main_out_enable}, 16'h0001);
  endtask
  task automatic sc_bat_under();
    battery_under <= 1'b1;
    step(5);
    host_u.write_reg(ADDR_STATUS, 16'h0003);
    rd_chk(ADDR_STATUS, 16'hFFFF, 16'h0002);
    battery_under <= 1'b0;
    step(5);
    host_u.write_reg(ADDR_STATUS, 16'h0002);
    rd_chk(ADDR_STATUS, 16'hFFFF, 16'h0000);
  endtask
  task automatic sc_bat_over();
    host_u.write_reg(ADDR_CONTROL, 16'h0040);
    battery_over <= 1'b1;
    step(5);
    battery_over <= 1'b0;
    host_u.write_reg(ADDR_CONTROL, 16'h0000);
    rd_chk(ADDR_STATUS, 16'hFFFF, 16'h0004);
    host_u.write_reg(ADDR_STATUS, 16'h0004);
    rd_chk(ADDR_STATUS, 16'hFFFF, 16'h0000);
  endtask
  task automatic sc_thermal();
    host_u.write_reg(ADDR_CONTROL, 16'h0018);
    step(3);
    chk({14'h0000, aux_out_enable, xcvr_tx_enable}, 16'h0003);
    {aux_hot, xcvr_hot, main_hot_prewarn, main_prewarn, xcvr_under} <= 5'h1F;
    step(5);
    chk({12'h000, aux_out_enable, xcvr_tx_enable, xcvr_fault}, 16'h0001);
    {main_prewarn, xcvr_under} <= 2'h0;
    rd_chk(ADDR_STATUS, 16'hFFFF, 16'h0F08);
    rd_chk(ADDR_MODE, 16'h001F, 16'h0008);
    host_u.write_reg(ADDR_STATUS, 16'h0F08);
    rd_chk(ADDR_STATUS, 16'hFFFF, 16'h0E00);
    {aux_hot, xcvr_hot, main_hot_prewarn} <= 3'h0;
    step(5);
    chk({14'h0000, aux_out_enable, xcvr_tx_enable}, 16'h0001);
    rd_chk(ADDR_CONTROL, 16'h0018, 16'h0010);
    host_u.write_reg(ADDR_STATUS, 16'h0E00);
    rd_chk(ADDR_STATUS, 16'hFFFF, 16'h0000);
  endtask
  task automatic sc_over_and_drop();
    host_u.write_reg(ADDR_CONTROL, 16'h0002);
    main_over <= 1'b1;
    wait_mode(mode_failsafe);
    step(2);
    chk({15'h0000, fail_output}, 16'h0001);
    rd_chk(ADDR_STATUS, 16'h0020, 16'h0020);
    main_over <= 1'b0;
    battery_por_low <= 1'b1;
    step(4);
    battery_por_low <= 1'b0;
    wait_mode(mode_init);
    rd_chk(ADDR_STATUS, 16'hFFFF, 16'h0001);
    chk({14'h0000, reset_out_n, fail_output}, 16'h0000);
    host_u.write_reg(ADDR_CONTROL, 16'h0006);
    main_over <= 1'b1;
    wait_mode(mode_restart);
    chk({14'h0000, reset_out_n, fail_output}, 16'h0001);
    main_over <= 1'b0;
    battery_por_low <= 1'b1;
    step(4);
    battery_por_low <= 1'b0;
    wait_mode(mode_init);
  endtask
  task automatic sc_chip_count();
    host_u.write_reg(ADDR_CONTROL, 16'h0020);
    for (int i = 1; i <= 16; i++)
    begin
      chip_hot <= 1'b1;
      step(8);
      chip_hot <= 1'b0;
      step(4);
      if (i >= 15)
        rd_chk(ADDR_STATUS, 16'h2000, (i == 16) ? 16'h2000 : 16'h0000);
    end
    host_u.write_reg(ADDR_STATUS, 16'h1000);
    rd_chk(ADDR_STATUS, 16'h1000, 16'h1000);
    wait_mode(mode_failsafe);
  endtask
  initial
  begin
    {reset_n, battery_por_low, battery_under, battery_over, main_prewarn, main_under, main_over,
      load_above_peak, aux_under, xcvr_under, aux_hot, xcvr_hot, main_hot_prewarn, chip_hot,
      bus_wake, wake_input, gpio_wake} = 17'h00000;
    main_above_rt1 = 1'b1;
    step(8);
    reset_n <= 1'b1;
    sc_power_on();
    sc_bat_under();
    sc_bat_over();
    sc_thermal();
    sc_over_and_drop();
    sc_chip_count();
    give_verdict();
  end
  initial
  begin
    step(5000);
    n_mismatch++;
    give_verdict();
  end
endmodule // tb_supply_thermal_supervisor
`default_nettype wire
